// *** fbs_defs.vh ***
// Purpose: constants for the fan boost, smoothing and table 1/2 config bank
// Assumes: 8-bit register port, byte addresses as printed
// Notes: timing counts are in 100 MHz clock cycles
`ifndef FBS_DEFS_VH
`define FBS_DEFS_VH
`define FBS_ADDR_BOOST_12 8'hC0
`define FBS_ADDR_BOOST_34 8'hC1
`define FBS_ADDR_SMOOTH 8'hC2
`define FBS_ADDR_TABLE_12 8'hC3
`define FBS_RST_BOOST_12 8'h44
`define FBS_RST_BOOST_34 8'h44
`define FBS_RST_SMOOTH 8'h00
`define FBS_RST_TABLE_12 8'h00
`define FBS_LO_NIB 3:0
`define FBS_HI_NIB 7:4
`define FBS_SPAN_ONE 2:0
`define FBS_USE_ONE 3
`define FBS_SPAN_TWO 6:4
`define FBS_USE_TWO 7
`define FBS_DUTY_MAX_CODE 4'hC
`define FBS_FULL_DUTY 4'hF
`define FBS_TICK_NS 100000
`define FBS_CLK_NS 10
`define FBS_TICK_CYC (`FBS_TICK_NS / `FBS_CLK_NS)
`endif

// *** fbs_config.v ***
// Purpose: fan boost bands, spike smoothing and table 1/2 floor/hysteresis bank
// Assumes: temperatures are signed half-degree codes, 9 bits, synchronous inputs
// Notes: filter is a first-order shift-based average ticked every 100 us
// Notes: boost trip levels and below-base flags come from the fan control core
// Notes: half-degree select scales zone 1/2 boost bands and the table step band
`include "fbs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fbs_config #(
    parameter TW = 9,
    parameter FW = 13,
    parameter TICK_CYC = `FBS_TICK_CYC
) (
    input wire clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    input wire table_pair_a_half_degree,
    input wire [TW-1:0] zone1_temp,
    input wire [TW-1:0] zone2_temp,
    input wire [TW-1:0] zone3_temp,
    input wire [TW-1:0] zone4_temp,
    input wire [4*TW-1:0] boost_trip,
    input wire [1:0] zone_below_base,
    output reg [TW-1:0] zone1_raw_out,
    output reg [TW-1:0] zone2_raw_out,
    output reg [FW-1:0] zone1_filtered,
    output reg [FW-1:0] zone2_filtered,
    output reg [TW-1:0] zone1_control_temp,
    output reg [TW-1:0] zone2_control_temp,
    output reg [3:0] boost_active,
    output reg [3:0] boost_duty_code,
    output reg [TW-1:0] table_pair_a_step_band,
    output reg [1:0] floor_request,
    output reg [3:0] table_pair_a_floor_duty
);
    reg rst_s1_reg;
    reg rst_s2_reg;
    wire rst_n = rst_s2_reg;
    reg [7:0] boost12_reg;
    reg [7:0] boost34_reg;
    reg [7:0] smooth_reg;
    reg [7:0] table12_reg;
    reg [19:0] tick_cnt_reg;
    reg tick_reg;
    wire [4*TW-1:0] temps = {zone4_temp, zone3_temp, zone2_temp, zone1_temp};
    wire [15:0] bands = {boost34_reg, boost12_reg};
    wire wr_boost12 = reg_wr & (reg_addr == `FBS_ADDR_BOOST_12);
    wire wr_boost34 = reg_wr & (reg_addr == `FBS_ADDR_BOOST_34);
    wire wr_smooth = reg_wr & (reg_addr == `FBS_ADDR_SMOOTH);
    wire wr_table12 = reg_wr & (reg_addr == `FBS_ADDR_TABLE_12);
    reg [7:0] rdata_next;
    wire [3:0] boost_set;
    wire [3:0] boost_clr;
    localparam AW = TW + 17;
    wire [2*AW-1:0] acc_flat;

    // release is synchronised so every flop leaves reset on the same edge
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // one flop set per register; unmapped writes decode to nothing
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            boost12_reg <= `FBS_RST_BOOST_12;
        else if (wr_boost12)
            boost12_reg <= reg_wdata;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            boost34_reg <= `FBS_RST_BOOST_34;
        else if (wr_boost34)
            boost34_reg <= reg_wdata;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            smooth_reg <= `FBS_RST_SMOOTH;
        else if (wr_smooth)
            smooth_reg <= reg_wdata;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            table12_reg <= `FBS_RST_TABLE_12;
        else if (wr_table12)
            table12_reg <= reg_wdata;
    end

    // unmapped reads answer zero rather than leaving stale data
    always @*
    begin
        rdata_next = 8'h00;
        case (reg_addr)
            `FBS_ADDR_BOOST_12: rdata_next = boost12_reg;
            `FBS_ADDR_BOOST_34: rdata_next = boost34_reg;
            `FBS_ADDR_SMOOTH: rdata_next = smooth_reg;
            `FBS_ADDR_TABLE_12: rdata_next = table12_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_ack <= 1'b0;
        else
            reg_ack <= reg_wr | reg_rd;
    end

    // a read in the same cycle as a write returns the old value
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_next;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end
        else if (tick_cnt_reg == TICK_CYC - 1)
        begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b1;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 20'h00001;
            tick_reg <= 1'b0;
        end
    end

    // time-constant shift per span code; tick 100 us, tau about 2^k ticks
    // 13.1 s ~ 2^17, 0.4 s ~ 2^12 ticks; codes in between step roughly to fit
    function [4:0] span_shift;
        input [2:0] code;
        begin
            case (code)
                3'h0: span_shift = 5'h11;
                3'h1: span_shift = 5'h10;
                3'h2: span_shift = 5'h0F;
                3'h3: span_shift = 5'h0F;
                3'h4: span_shift = 5'h0E;
                3'h5: span_shift = 5'h0D;
                3'h6: span_shift = 5'h0C;
                3'h7: span_shift = 5'h0C;
                default: span_shift = 5'h11;
            endcase
        end
    endfunction

    // smoothing accumulators for zones 1/2 only; fraction bits give finer readout
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : smooth_ch
            wire [2:0] code = g ? smooth_reg[`FBS_SPAN_TWO] : smooth_reg[`FBS_SPAN_ONE];
            wire signed [AW-1:0] sample = {temps[g*TW +: TW], 17'h00000};
            reg signed [AW-1:0] acc_reg;
            wire signed [AW-1:0] diff = sample - acc_reg;
            wire signed [AW-1:0] step = diff >>> span_shift(code);
            assign acc_flat[g*AW +: AW] = acc_reg;
            // filter runs continuously regardless of the use bit
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    acc_reg <= {AW{1'b0}};
                else if (tick_reg)
                    acc_reg <= acc_reg + step;
            end
        end
    endgenerate

    // boost hold per zone: set on trip, held until band below trip
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : boost_ch
            wire signed [TW:0] t = {temps[g*TW+TW-1], temps[g*TW +: TW]};
            wire signed [TW:0] trip = {boost_trip[g*TW+TW-1], boost_trip[g*TW +: TW]};
            wire [3:0] band = bands[g*4 +: 4];
            // band counted in half-degree code units; half-degree mode only on zones 1/2
            wire half = table_pair_a_half_degree & (g < 2);
            wire signed [TW:0] band_u = half ? {{(TW-3){1'b0}}, band} :
                {{(TW-4){1'b0}}, band, 1'b0};
            wire signed [TW:0] release_lvl = trip - band_u;
            assign boost_set[g] = t > trip;
            assign boost_clr[g] = t <= release_lvl;
        end
    endgenerate

    // a trip wins over a release in the same cycle, so the hold never drops early
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            boost_active <= 4'h0;
        else
            boost_active <= (boost_active & ~boost_clr) | boost_set;
    end

    wire [TW-1:0] zone1_control_next = smooth_reg[`FBS_USE_ONE] ?
        acc_flat[AW-1 -: TW] : zone1_temp;
    wire [TW-1:0] zone2_control_next = smooth_reg[`FBS_USE_TWO] ?
        acc_flat[2*AW-1 -: TW] : zone2_temp;
    // zero band is legal but lets control chatter between steps
    wire [TW-1:0] step_band_next = table_pair_a_half_degree ?
        {{(TW-4){1'b0}}, table12_reg[`FBS_LO_NIB]} :
        {{(TW-5){1'b0}}, table12_reg[`FBS_LO_NIB], 1'b0};
    wire [3:0] floor_code = table12_reg[`FBS_HI_NIB];
    // unmapped codes clamp so the fan never sees an undefined duty
    wire [3:0] floor_duty_next = (floor_code > `FBS_DUTY_MAX_CODE) ?
        `FBS_DUTY_MAX_CODE : floor_code;

    // readouts: raw stays raw whatever the use bits say
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zone1_raw_out <= {TW{1'b0}};
            zone2_raw_out <= {TW{1'b0}};
            zone1_filtered <= {FW{1'b0}};
            zone2_filtered <= {FW{1'b0}};
        end
        else
        begin
            zone1_raw_out <= zone1_temp;
            zone2_raw_out <= zone2_temp;
            zone1_filtered <= acc_flat[AW-1 -: FW];
            zone2_filtered <= acc_flat[2*AW-1 -: FW];
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zone1_control_temp <= {TW{1'b0}};
            zone2_control_temp <= {TW{1'b0}};
        end
        else
        begin
            zone1_control_temp <= zone1_control_next;
            zone2_control_temp <= zone2_control_next;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            boost_duty_code <= 4'h0;
        else
            boost_duty_code <= (|boost_active) ? `FBS_FULL_DUTY : 4'h0;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            table_pair_a_step_band <= {TW{1'b0}};
            floor_request <= 2'b00;
            table_pair_a_floor_duty <= 4'h0;
        end
        else
        begin
            table_pair_a_step_band <= step_band_next;
            floor_request <= zone_below_base;
            table_pair_a_floor_duty <= floor_duty_next;
        end
    end
endmodule // fbs_config
`default_nettype wire

// *** fbs_config_assertions.sv ***
// Purpose: port checks for the boost/smoothing/table config bank
// Assumes: one clock, async active-low reset
// Notes: boost release depth is left to the bench
`timescale 1ns/1ps
`default_nettype none
module fbs_config_chk #(parameter TW = 9) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic [TW-1:0] zone3_temp,
    input wire logic [4*TW-1:0] boost_trip,
    input wire logic [1:0] zone_below_base,
    input wire logic [3:0] boost_active,
    input wire logic [3:0] boost_duty_code,
    input wire logic [1:0] floor_request,
    input wire logic [3:0] table_pair_a_floor_duty
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ack_after_req_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("no ack after strobe");
    ack_no_req_a: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
        else $error("ack without strobe");
    unmapped_zero_a: assert property (
        reg_rd && reg_addr[7:2] != 6'h30 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property ($changed(reg_rdata) |-> $past(reg_rd))
        else $error("read data moved without read");
    floor_follow_a: assert property (floor_request == $past(zone_below_base))
        else $error("floor request lag wrong");
    boost_trip_a: assert property (
        $signed(zone3_temp) > $signed(boost_trip[3*TW-1:2*TW]) |=> boost_active[2])
        else $error("boost not raised");
    boost_full_a: assert property (
        boost_duty_code == ($past(|boost_active) ? 4'hF : 4'h0))
        else $error("boost duty wrong");
    floor_clamp_a: assert property (table_pair_a_floor_duty <= 4'hC)
        else $error("floor duty unmapped");
    cover property (reg_wr);
    cover property (reg_rd ##1 reg_ack);
    cover property ($fell(boost_active[2]));
endmodule // fbs_config_chk
`default_nettype wire

// *** fbs_config_tb_top.sv ***
// Purpose: self-checking bench for the config bank
// Assumes: filter tick shortened to 10 cycles
// Notes: read data is checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module fbs_config_tb_top;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, half = 0, rd_d = 0, ack;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, v, e;
    logic [8:0] t1 = 0, t2 = 0, t3 = 0, t4 = 0, raw1, raw2, ct1, ct2, band;
    logic [35:0] trip = {9'h0C8, 9'h064, 9'h0C8, 9'h0C8};
    logic [1:0] below = 2'h0, freq;
    logic [3:0] act, duty, floor_d, c;
    logic [12:0] f1, f2;
    logic [7:0] expq[$];
    int bad_count = 0, compares = 0, cyc = 0, i;
    always #5 clk = ~clk;
    fbs_config #(.TICK_CYC(10)) i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .reg_ack(ack), .table_pair_a_half_degree(half), .zone1_temp(t1), .zone2_temp(t2),
        .zone3_temp(t3), .zone4_temp(t4), .boost_trip(trip), .zone_below_base(below),
        .zone1_raw_out(raw1), .zone2_raw_out(raw2), .zone1_filtered(f1), .zone2_filtered(f2),
        .zone1_control_temp(ct1), .zone2_control_temp(ct2), .boost_active(act),
        .boost_duty_code(duty), .table_pair_a_step_band(band), .floor_request(freq),
        .table_pair_a_floor_duty(floor_d));
    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ack is a one-cycle pulse, so the monitor looks in exactly that cycle
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        cyc <= cyc + 1;
        if (cyc > 5000)
        begin
            bad_count++;
            end_of_test();
        end
        if (ack && rd_d)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
            `CHK("rdata", e, rdata)
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        expq.push_back(x);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial
    begin
        i = $urandom(1778);
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'hC0, 8'h44);
        rd(8'hC1, 8'h44);
        rd(8'hC2, 8'h00);
        rd(8'hC3, 8'h00);
        wr(8'hC5, 8'hA5);
        rd(8'hC5, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            wr(8'hC0 + i[7:0], v);
            rd(8'hC0 + i[7:0], v);
        end
        // every floor code, half-degree toggled to show both band scales
        for (i = 0; i < 16; i++)
        begin
            c = i[3:0];
            wr(8'hC3, {c, 4'h5});
            half <= c[0];
            settle();
            `CHK("floor", (c > 4'hC) ? 4'hC : c, floor_d)
            `CHK("band", c[0] ? 9'd5 : 9'd10, band)
        end
        wr(8'hC1, 8'h45);
        @(posedge clk);
        t3 <= 9'd110;
        settle();
        `CHK("boost", 4'hF, duty)
        @(posedge clk);
        t3 <= 9'd91;
        settle();
        `CHK("hold", 1'b1, act[2])
        @(posedge clk);
        t3 <= 9'd90;
        settle();
        `CHK("release", 4'h0, duty)
        // fastest span so the filtered value moves within a few ticks
        for (i = 0; i < 2; i++)
        begin
            wr(8'hC2, i[0] ? 8'hFF : 8'h77);
            @(posedge clk);
            below <= $urandom;
            t1 <= $urandom_range(127, 64);
            t2 <= $urandom_range(127, 64);
            t4 <= $urandom_range(149, 0);
            repeat (100) @(posedge clk);
            #1;
            `CHK("floor_req", below, freq)
            `CHK("raw1", t1, raw1)
            `CHK("raw2", t2, raw2)
            `CHK("filt1", 1'b1, f1 != 13'h0000)
            `CHK("filt2", 1'b1, f2 != 13'h0000)
            `CHK("ctl1", i[0] ? f1[12:4] : t1, ct1)
            `CHK("ctl2", i[0] ? f2[12:4] : t2, ct2)
        end
        repeat (5) @(posedge clk);
        end_of_test();
    end
endmodule // fbs_config_tb_top
bind fbs_config fbs_config_chk #(.TW(TW)) i_chk (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .zone3_temp(zone3_temp), .boost_trip(boost_trip),
    .zone_below_base(zone_below_base), .boost_active(boost_active),
    .boost_duty_code(boost_duty_code), .floor_request(floor_request),
    .table_pair_a_floor_duty(table_pair_a_floor_duty));
`default_nettype wire
